// ===== core/bst_pkg.sv
package bst_pkg;
   // instruction register
   localparam int IR_W = 3;
   localparam logic [2:0] IR_EXTEST = 3'h0;
   localparam logic [2:0] IR_IDCODE = 3'h3;
   localparam logic [2:0] IR_SAMPLE = 3'h4;
   localparam logic [2:0] IR_BYPASS = 3'h7;
   localparam logic [2:0] IR_CAPT = 3'h1; // fixed capture pattern, lsb first
   // pads and data registers
   localparam int PADS = 4;
   localparam int ID_W = 32;
   localparam logic [31:0] ID_VALUE = 32'h0000_0001; // arbitrary value, lsb must be 1
   // far-side limit on the test clock, kept for reference by the bench
   localparam int TCK_MAX_HZ = 10_000_000;
   // register map, byte addresses
   localparam int AW = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam int CTRL_SWRST = 0;
   localparam int STAT_TLR = 0;
   localparam int STAT_SEL = 1;
   localparam int STAT_EXT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // sequencer states, one-hot
   typedef enum logic [15:0] {
      ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SDS = 16'h0004, ST_CDR = 16'h0008,
      ST_SDR = 16'h0010, ST_E1D = 16'h0020, ST_PDR = 16'h0040, ST_E2D = 16'h0080,
      ST_UDR = 16'h0100, ST_SIS = 16'h0200, ST_CIR = 16'h0400, ST_SIR = 16'h0800,
      ST_E1I = 16'h1000, ST_PIR = 16'h2000, ST_E2I = 16'h4000, ST_UIR = 16'h8000
   } bst_state_t;
endpackage

// ===== core/bst_tap_if.sv
`timescale 1ns/1ps
interface bst_tap_if;
   logic tlr;
   logic sel_ir;
   logic cap_dr;
   logic cap_ir;
   logic sh_dr;
   logic sh_ir;
   logic upd_dr;
   logic upd_ir;
   logic enable;
   modport seq (output tlr, sel_ir, cap_dr, cap_ir, sh_dr, sh_ir, upd_dr, upd_ir, enable);
   modport user (input tlr, sel_ir, cap_dr, cap_ir, sh_dr, sh_ir, upd_dr, upd_ir, enable);
endinterface

// ===== core/bst_seq.sv
`timescale 1ns/1ps
module bst_seq import bst_pkg::*; (
   // test clock side
   input wire logic tck,
   input wire logic scan_rst,
   input wire logic sw_rst,
   input wire logic tms,
   // decoded controls
   bst_tap_if.seq tp
);
   bst_state_t st_ff, nxt_st;

   // next state from the sampled mode-select level
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_TLR: nxt_st = tms ? ST_TLR : ST_RTI;
         ST_RTI: nxt_st = tms ? ST_SDS : ST_RTI;
         ST_SDS: nxt_st = tms ? ST_SIS : ST_CDR;
         ST_CDR: nxt_st = tms ? ST_E1D : ST_SDR;
         ST_SDR: nxt_st = tms ? ST_E1D : ST_SDR;
         ST_E1D: nxt_st = tms ? ST_UDR : ST_PDR;
         ST_PDR: nxt_st = tms ? ST_E2D : ST_PDR;
         ST_E2D: nxt_st = tms ? ST_UDR : ST_SDR;
         ST_UDR: nxt_st = tms ? ST_SDS : ST_RTI;
         ST_SIS: nxt_st = tms ? ST_TLR : ST_CIR;
         ST_CIR: nxt_st = tms ? ST_E1I : ST_SIR;
         ST_SIR: nxt_st = tms ? ST_E1I : ST_SIR;
         ST_E1I: nxt_st = tms ? ST_UIR : ST_PIR;
         ST_PIR: nxt_st = tms ? ST_E2I : ST_PIR;
         ST_E2I: nxt_st = tms ? ST_UIR : ST_SIR;
         ST_UIR: nxt_st = tms ? ST_SDS : ST_RTI;
         default: nxt_st = ST_TLR;
      endcase
      if (sw_rst) begin
         nxt_st = ST_TLR;
      end
   end

   // pins reset at once; the clock may be stopped while they are asserted
   always_ff @(posedge tck or posedge scan_rst) begin
      if (scan_rst) begin
         st_ff <= ST_TLR;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // state decode
   assign tp.tlr = (st_ff == ST_TLR);
   assign tp.sel_ir = |(st_ff & 16'hfe00);
   assign tp.cap_dr = (st_ff == ST_CDR);
   assign tp.cap_ir = (st_ff == ST_CIR);
   assign tp.sh_dr = (st_ff == ST_SDR);
   assign tp.sh_ir = (st_ff == ST_SIR);
   assign tp.upd_dr = (st_ff == ST_UDR);
   assign tp.upd_ir = (st_ff == ST_UIR);
   assign tp.enable = tp.sh_dr | tp.sh_ir;

   tms_reset_a: assert property (@(posedge tck) disable iff (scan_rst)
      tms [*5] |=> st_ff == ST_TLR) else $error("five tms highs did not reach reset");
   sel_ir_a: assert property (@(posedge tck) disable iff (scan_rst)
      (st_ff == ST_SDS && tms) |=> tp.sel_ir) else $error("select not high on ir path");
   pin_reset_a: assert property (@(posedge tck)
      scan_rst |-> tp.tlr) else $error("reset pin did not force reset state");
endmodule

// ===== core/bst_cell.sv
`timescale 1ns/1ps
module bst_cell (
   // test clock and controls
   input wire logic tck,
   input wire logic scan_rst,
   input wire logic capture,
   input wire logic shift,
   input wire logic update,
   input wire logic mode,
   // chain
   input wire logic scan_in,
   output logic scan_out,
   // pad and logic array values, already in the test clock domain
   input wire logic pad_in_s,
   input wire logic fn_out_s,
   input wire logic fn_oe_s,
   // test drive
   output logic drv_val,
   output logic drv_en
);
   logic dsc_ff, csc_ff, dup_ff, cup_ff;
   logic nxt_dsc, nxt_csc, dir_hi;

   // direction steering the data cell: test value under extest, else functional
   assign dir_hi = mode ? cup_ff : fn_oe_s;

   // scan stages: capture, then shift data cell into direction cell
   always_comb begin
      nxt_dsc = dsc_ff;
      nxt_csc = csc_ff;
      if (capture) begin
         nxt_dsc = dir_hi ? fn_out_s : pad_in_s;
         nxt_csc = fn_oe_s;
      end else if (shift) begin
         nxt_dsc = scan_in;
         nxt_csc = dsc_ff;
      end
   end

   always_ff @(posedge tck or posedge scan_rst) begin
      if (scan_rst) begin
         dsc_ff <= 1'b0;
         csc_ff <= 1'b0;
      end else begin
         dsc_ff <= nxt_dsc;
         csc_ff <= nxt_csc;
      end
   end

   // update stages load on the falling edge so pads change away from sampling
   always_ff @(negedge tck or posedge scan_rst) begin
      if (scan_rst) begin
         dup_ff <= 1'b0;
         cup_ff <= 1'b0;
      end else if (update) begin
         dup_ff <= dsc_ff;
         cup_ff <= csc_ff;
      end
   end

   assign scan_out = csc_ff;
   assign drv_val = dup_ff;
   assign drv_en = cup_ff;

   cap_dir_a: assert property (@(posedge tck) disable iff (scan_rst)
      (capture && !dir_hi) |=> dsc_ff == $past(pad_in_s)) else $error("input not captured");
   upd_cell_a: assert property (@(negedge tck) disable iff (scan_rst)
      update |=> dup_ff == $past(dsc_ff) && cup_ff == $past(csc_ff))
      else $error("update stage missed");
endmodule

// ===== core/bst_top.sv
`timescale 1ns/1ps
// Behaviour
// - sixteen-state sequencer stepped by sampled tms
// - select high on instruction path, low otherwise
// - capture parallel-loads the selected register
// - shift moves data out while new enters
// - update loads instruction or pad drive stages
// - four chained pad cells per group
// - normal mode passes logic array and pads
// - data cell and direction cell, scan then update
// - direction low captures pad, high captures array
// - mode high drives scan data, low functional
// - sample on rising, tdo changes on falling
// - extest drive loaded on falling edge, applied to pads on core_clk after two sync stages
// - three-bit instruction, 000 011 100 111 codes
// - bypass is one flip-flop stage
// - identification register default after reset
module bst_top import bst_pkg::*; (
   // system clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // axi4-lite write channels
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // test port pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe_n,
   input wire logic power_up_reset_in,
   input wire logic scan_logic_reset_in,
   output logic test_logic_reset,
   // pads
   input wire logic [PADS-1:0] pad_in,
   output logic [PADS-1:0] pad_out,
   output logic [PADS-1:0] pad_oe_n,
   // logic array side
   input wire logic [PADS-1:0] la_out,
   input wire logic [PADS-1:0] la_oe,
   output logic [PADS-1:0] la_in
);
   bst_tap_if tp ();
   logic scan_rst;
   logic [1:0] swr_sy_ff;
   logic [PADS-1:0] pin_t1_ff, pin_t2_ff, fo_t1_ff, fo_t2_ff, fe_t1_ff, fe_t2_ff;
   logic [IR_W-1:0] ir_sr_ff, nxt_ir_sr, ir_ff;
   logic byp_ff, nxt_byp;
   logic [ID_W-1:0] id_sr_ff, nxt_id_sr;
   logic mode, bsr_sel, dr_lsb;
   logic [PADS:0] chain;
   logic [PADS-1:0] drv_val, drv_en;
   logic tdo_ff, tdo_oe_n_ff;
   // core domain state
   logic ctrl_swrst_ff, nxt_ctrl_swrst;
   logic [2:0] st_s1_ff, st_s2_ff;
   logic [PADS-1:0] dv_s1_ff, dv_s2_ff, de_s1_ff, de_s2_ff, pi_c1_ff, la_in_ff;
   logic [PADS-1:0] pad_out_ff, nxt_pad_out, pad_oe_n_ff, nxt_pad_oe_n;
   logic aw_ok_ff, nxt_aw_ok, w_ok_ff, nxt_w_ok, bv_ff, nxt_bv, rv_ff, nxt_rv;
   logic [AW-1:0] awa_ff, nxt_awa;
   logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
   logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;

   // either pin resets the test logic immediately
   assign scan_rst = power_up_reset_in | scan_logic_reset_in;

   bst_seq u_seq (
      .tck(tck),
      .scan_rst(scan_rst),
      .sw_rst(swr_sy_ff[1]),
      .tms(tms),
      .tp(tp)
   );

   // level crossings into the test clock domain; second stage only is read
   always_ff @(posedge tck or posedge scan_rst) begin
      if (scan_rst) begin
         swr_sy_ff <= 2'h0;
         pin_t1_ff <= '0;
         pin_t2_ff <= '0;
         fo_t1_ff <= '0;
         fo_t2_ff <= '0;
         fe_t1_ff <= '0;
         fe_t2_ff <= '0;
      end else begin
         swr_sy_ff <= {swr_sy_ff[0], ctrl_swrst_ff};
         pin_t1_ff <= pad_in;
         pin_t2_ff <= pin_t1_ff;
         fo_t1_ff <= la_out;
         fo_t2_ff <= fo_t1_ff;
         fe_t1_ff <= la_oe;
         fe_t2_ff <= fe_t1_ff;
      end
   end

   // instruction decode; unknown codes behave as bypass
   assign mode = (ir_ff == IR_EXTEST);
   assign bsr_sel = mode | (ir_ff == IR_SAMPLE);

   // one group of four chained pad cells
   assign chain[0] = tdi;
   for (genvar i = 0; i < PADS; i++) begin : g_cell
      bst_cell u_cell (
         .tck(tck),
         .scan_rst(scan_rst),
         .capture(tp.cap_dr & bsr_sel),
         .shift(tp.sh_dr & bsr_sel),
         .update(tp.upd_dr & bsr_sel),
         .mode(mode),
         .scan_in(chain[i]),
         .scan_out(chain[i+1]),
         .pad_in_s(pin_t2_ff[i]),
         .fn_out_s(fo_t2_ff[i]),
         .fn_oe_s(fe_t2_ff[i]),
         .drv_val(drv_val[i]),
         .drv_en(drv_en[i])
      );
   end

   // instruction, bypass and identification shift stages
   always_comb begin
      nxt_ir_sr = ir_sr_ff;
      nxt_byp = byp_ff;
      nxt_id_sr = id_sr_ff;
      if (tp.cap_ir) begin
         nxt_ir_sr = IR_CAPT;
      end else if (tp.sh_ir) begin
         nxt_ir_sr = {tdi, ir_sr_ff[IR_W-1:1]};
      end
      if (tp.cap_dr) begin
         nxt_byp = 1'b0;
         nxt_id_sr = ID_VALUE;
      end else if (tp.sh_dr) begin
         nxt_byp = tdi;
         nxt_id_sr = {tdi, id_sr_ff[ID_W-1:1]};
      end
   end

   always_ff @(posedge tck or posedge scan_rst) begin
      if (scan_rst) begin
         ir_sr_ff <= IR_CAPT;
         byp_ff <= 1'b0;
         id_sr_ff <= ID_VALUE;
      end else begin
         ir_sr_ff <= nxt_ir_sr;
         byp_ff <= nxt_byp;
         id_sr_ff <= nxt_id_sr;
      end
   end

   // instruction output stage; reset state restores the identification default
   always_ff @(negedge tck or posedge scan_rst) begin
      if (scan_rst) begin
         ir_ff <= IR_IDCODE;
      end else if (tp.tlr) begin
         ir_ff <= IR_IDCODE;
      end else if (tp.upd_ir) begin
         ir_ff <= ir_sr_ff;
      end
   end

   // tdo source for the selected path
   always_comb begin
      if (bsr_sel) begin
         dr_lsb = chain[PADS];
      end else if (ir_ff == IR_IDCODE) begin
         dr_lsb = id_sr_ff[0];
      end else begin
         dr_lsb = byp_ff;
      end
   end

   // tdo moves on the falling edge so the far end samples a settled bit
   always_ff @(negedge tck or posedge scan_rst) begin
      if (scan_rst) begin
         tdo_ff <= 1'b0;
         tdo_oe_n_ff <= 1'b1;
      end else begin
         tdo_ff <= tp.sh_ir ? ir_sr_ff[0] : dr_lsb;
         tdo_oe_n_ff <= ~tp.enable;
      end
   end

   assign tdo = tdo_ff;
   assign tdo_oe_n = tdo_oe_n_ff;
   assign test_logic_reset = tp.tlr;

   // core side: status and drive values cross as levels; drive bits only
   // change at update, long before the two-stage delay matters
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_s1_ff <= 3'h0;
         st_s2_ff <= 3'h0;
         dv_s1_ff <= '0;
         dv_s2_ff <= '0;
         de_s1_ff <= '0;
         de_s2_ff <= '0;
         pi_c1_ff <= '0;
         la_in_ff <= '0;
      end else begin
         st_s1_ff <= {mode, tp.sel_ir, tp.tlr};
         st_s2_ff <= st_s1_ff;
         dv_s1_ff <= drv_val;
         dv_s2_ff <= dv_s1_ff;
         de_s1_ff <= drv_en;
         de_s2_ff <= de_s1_ff;
         pi_c1_ff <= pad_in;
         la_in_ff <= pi_c1_ff;
      end
   end

   // pad drivers: test values under extest, functional otherwise
   always_comb begin
      if (st_s2_ff[STAT_EXT]) begin
         nxt_pad_out = dv_s2_ff;
         nxt_pad_oe_n = ~de_s2_ff;
      end else begin
         nxt_pad_out = la_out;
         nxt_pad_oe_n = ~la_oe;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pad_out_ff <= '0;
         pad_oe_n_ff <= '1;
      end else begin
         pad_out_ff <= nxt_pad_out;
         pad_oe_n_ff <= nxt_pad_oe_n;
      end
   end

   assign pad_out = pad_out_ff;
   assign pad_oe_n = pad_oe_n_ff;
   assign la_in = la_in_ff;

   // axi4-lite slave: address and data taken in either order, then response
   always_comb begin
      nxt_aw_ok = aw_ok_ff;
      nxt_w_ok = w_ok_ff;
      nxt_awa = awa_ff;
      nxt_wd = wd_ff;
      nxt_bv = bv_ff;
      nxt_br = br_ff;
      nxt_ctrl_swrst = ctrl_swrst_ff;
      nxt_rv = rv_ff;
      nxt_rd = rd_ff;
      nxt_rr = rr_ff;
      if (s_axi_awvalid && !aw_ok_ff) begin
         nxt_aw_ok = 1'b1;
         nxt_awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_ok_ff) begin
         nxt_w_ok = 1'b1;
         nxt_wd = s_axi_wdata;
      end
      if (aw_ok_ff && w_ok_ff && !bv_ff) begin
         nxt_bv = 1'b1;
         nxt_br = (awa_ff == REG_CTRL || awa_ff == REG_STAT) ? RESP_OKAY : RESP_SLVERR;
         if (awa_ff == REG_CTRL && s_axi_wstrb[0]) begin
            nxt_ctrl_swrst = wd_ff[CTRL_SWRST];
         end
      end
      if (bv_ff && s_axi_bready) begin
         nxt_bv = 1'b0;
         nxt_aw_ok = 1'b0;
         nxt_w_ok = 1'b0;
      end
      if (s_axi_arvalid && !rv_ff) begin
         nxt_rv = 1'b1;
         nxt_rr = RESP_OKAY;
         nxt_rd = 32'h0000_0000;
         case (s_axi_araddr)
            REG_CTRL: nxt_rd[CTRL_SWRST] = ctrl_swrst_ff;
            REG_STAT: nxt_rd[2:0] = st_s2_ff;
            default: nxt_rr = RESP_SLVERR;
         endcase
      end else if (rv_ff && s_axi_rready) begin
         nxt_rv = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         aw_ok_ff <= 1'b0;
         w_ok_ff <= 1'b0;
         awa_ff <= '0;
         wd_ff <= 32'h0000_0000;
         bv_ff <= 1'b0;
         br_ff <= RESP_OKAY;
         ctrl_swrst_ff <= 1'b0;
         rv_ff <= 1'b0;
         rd_ff <= 32'h0000_0000;
         rr_ff <= RESP_OKAY;
      end else begin
         aw_ok_ff <= nxt_aw_ok;
         w_ok_ff <= nxt_w_ok;
         awa_ff <= nxt_awa;
         wd_ff <= nxt_wd;
         bv_ff <= nxt_bv;
         br_ff <= nxt_br;
         ctrl_swrst_ff <= nxt_ctrl_swrst;
         rv_ff <= nxt_rv;
         rd_ff <= nxt_rd;
         rr_ff <= nxt_rr;
      end
   end

   assign s_axi_awready = ~aw_ok_ff;
   assign s_axi_wready = ~w_ok_ff;
   assign s_axi_bvalid = bv_ff;
   assign s_axi_bresp = br_ff;
   assign s_axi_arready = ~rv_ff;
   assign s_axi_rvalid = rv_ff;
   assign s_axi_rdata = rd_ff;
   assign s_axi_rresp = rr_ff;

   ir_capture_a: assert property (@(posedge tck) disable iff (scan_rst)
      tp.cap_ir |=> ir_sr_ff == IR_CAPT) else $error("ir capture value wrong");
   ir_shift_a: assert property (@(posedge tck) disable iff (scan_rst)
      tp.sh_ir |=> ir_sr_ff[IR_W-2:0] == $past(ir_sr_ff[IR_W-1:1])
      && ir_sr_ff[IR_W-1] == $past(tdi))
      else $error("ir shift wrong");
   ir_update_a: assert property (@(negedge tck) disable iff (scan_rst)
      (tp.upd_ir && !tp.tlr) |=> ir_ff == $past(ir_sr_ff)) else $error("ir not updated");
   bypass_stage_a: assert property (@(posedge tck) disable iff (scan_rst)
      (tp.sh_dr && ir_ff == IR_BYPASS) |=> byp_ff == $past(tdi)) else $error("bypass delay");
   // the enable flop lags the state by one fall, so the release is judged on the past state
   tdo_enable_a: assert property (@(negedge tck) disable iff (scan_rst)
      tp.enable |=> !tdo_oe_n_ff ##1 ($past(tp.enable) || tdo_oe_n_ff))
      else $error("tdo enable");
   id_default_a: assert property (@(negedge tck) disable iff (scan_rst)
      tp.tlr |=> ir_ff == IR_IDCODE) else $error("id not default after reset");
   pad_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !st_s2_ff[STAT_EXT] |=> pad_out_ff == $past(la_out)) else $error("functional drive");
   bresp_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (bv_ff && !s_axi_bready) |=> bv_ff && $stable(br_ff)) else $error("bvalid dropped");
endmodule

// ===== verification/bst_host.sv
`timescale 1ns/1ps
module bst_host (
   // test port lines
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n
);
   // tck stands low outside frames; the host only clocks while a step runs
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // one test clock cycle, entered right at the previous fall
   task automatic step(input logic m, input logic d, output logic o, output logic oe_n);
      tms = m;
      tdi = d;
      #32;
      // tdo moved at the last fall, so it is settled here; nothing holds a released
      // line, so the model shows the inverse of the last bit while it is released
      o = tdo_oe_n ? ~tdo : tdo;
      oe_n = tdo_oe_n;
      tck = 1'b1;
      #68; // long high phase keeps the cycle at 100 ns, 10 MHz
      tck = 1'b0;
   endtask
endmodule

// ===== verification/bst_top_tb_top.sv
`timescale 1ns/1ps
module bst_top_tb_top import bst_pkg::*;;
   // bus and pin signals, named as the design ports
   logic core_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, q, v, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic tck, tms, tdi, tdo, tdo_oe_n, power_up_reset_in, scan_logic_reset_in;
   logic test_logic_reset, o, oe;
   logic [PADS-1:0] pad_in, pad_out, pad_oe_n, la_out, la_oe, la_in;
   logic [7:0] e;
   int n_mismatch, n_tests;

   bst_top dut_u (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tck, .tms, .tdi, .tdo, .tdo_oe_n,
      .power_up_reset_in, .scan_logic_reset_in, .test_logic_reset, .pad_in, .pad_out,
      .pad_oe_n, .la_out, .la_oe, .la_in);
   bst_host host_u (.tck, .tms, .tdi, .tdo, .tdo_oe_n);

   // 200 MHz system clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // write: address and data offered together, each dropped once taken
   task automatic axw(input logic [AW-1:0] a, input logic [31:0] wd, input logic [1:0] er);
      logic done;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= wd;
      s_axi_wvalid <= 1'b1;
      // bready rises only once bvalid is seen, so the slave must hold its response
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         done = s_axi_bvalid && s_axi_bready;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!done);
      s_axi_bready <= 1'b0;
      chk("bresp", s_axi_bresp, er);
   endtask

   task automatic axr(input logic [AW-1:0] a, output logic [31:0] rd, output logic [1:0] rr);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      // wait for the answer however long it takes; only the watchdog ends it
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // one register scan from idle back to idle, lsb first
   task automatic scan(input bit ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic so, soe;
      dout = '0;
      host_u.step(1'b1, 1'b0, so, soe);
      if (ir) host_u.step(1'b1, 1'b0, so, soe);
      host_u.step(1'b0, 1'b0, so, soe);
      host_u.step(1'b0, 1'b0, so, soe);
      for (int k = 0; k < n; k++) begin
         host_u.step(k == n - 1, din[k], so, soe);
         dout[k] = so;
         chk("tdo_oe_n in shift", soe, 0);
      end
      host_u.step(1'b1, 1'b0, so, soe);
      host_u.step(1'b0, 1'b0, so, soe);
      chk("tdo_oe_n after shift", soe, 1);
   endtask

   // drive stages: direction high means the pad is driven with the data bit
   task automatic pads_chk(input logic [7:0] c);
      for (int i = 0; i < PADS; i++) begin
         chk("pad_oe_n", pad_oe_n[i], !c[6-2*i]);
         if (c[6-2*i]) chk("pad_out", pad_out[i], c[7-2*i]);
      end
   endtask

   // watchdog: the whole run needs some 18 us
   initial begin
      #200_000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      void'($urandom(79970));
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      power_up_reset_in = 1'b1;
      scan_logic_reset_in = 1'b0;
      {pad_in, la_out, la_oe} = 12'($urandom);
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      power_up_reset_in <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("test_logic_reset", test_logic_reset, 1);
      chk("tdo_oe_n", tdo_oe_n, 1);
      axr(REG_STAT, d, r);
      chk("stat", d, 32'h1);
      chk("rresp", r, RESP_OKAY);
      axr(4'h8, d, r);
      chk("rresp", r, RESP_SLVERR);
      chk("rdata", d, 0);
      axw(4'hc, 32'h1, RESP_SLVERR);
      $display("test reset done");
      // default data register after reset is the identification word
      host_u.step(1'b0, 1'b0, o, oe);
      chk("test_logic_reset", test_logic_reset, 0);
      scan(0, 32, $urandom, q);
      chk("id", q, ID_VALUE);
      scan(1, 3, IR_BYPASS, q);
      chk("ir capture", q[2:0], IR_CAPT);
      v = $urandom;
      scan(0, 32, v, q);
      chk("bypass", q, {v[30:0], 1'b0});
      $display("test scan paths done");
      // normal mode, then sample capture of pads and array values
      pads_chk({la_out[0], la_oe[0], la_out[1], la_oe[1], la_out[2], la_oe[2], la_out[3],
                la_oe[3]} & 8'hff);
      chk("la_in", la_in, pad_in);
      scan(1, 3, IR_SAMPLE, q);
      for (int i = 0; i < PADS; i++) begin
         e[6-2*i] = la_oe[i];
         e[7-2*i] = la_oe[i] ? la_out[i] : pad_in[i];
      end
      v = $urandom;
      scan(0, 8, v, q);
      chk("sample capture", q[7:0], e);
      $display("test sample done");
      // preloaded stages reach the pads once external test is loaded
      scan(1, 3, IR_EXTEST, q);
      pads_chk(v[7:0]);
      axr(REG_STAT, d, r);
      chk("stat ext", d[STAT_EXT], 1);
      v = $urandom;
      scan(0, 8, v, q);
      pads_chk(v[7:0]);
      $display("test extest done");
      // reset pin in mid-run falls back to identification and normal pads
      @(posedge core_clk);
      scan_logic_reset_in <= 1'b1;
      @(posedge core_clk);
      // a test clock edge with tms low must not leave reset while the pin is held
      host_u.step(1'b0, 1'b0, o, oe);
      chk("tdo_oe_n in reset", oe, 1);
      repeat (20) @(posedge core_clk);
      chk("test_logic_reset", test_logic_reset, 1);
      scan_logic_reset_in <= 1'b0;
      chk("pad_out", pad_out, la_out);
      host_u.step(1'b0, 1'b0, o, oe);
      scan(0, 32, 32'h0, q);
      chk("id", q, ID_VALUE);
      $display("test scan reset done");
      // soft reset through the control register
      axw(REG_CTRL, 32'h1, RESP_OKAY);
      repeat (4) host_u.step(1'b0, 1'b0, o, oe);
      chk("test_logic_reset", test_logic_reset, 1);
      axr(REG_STAT, d, r);
      chk("stat tlr", d[STAT_TLR], 1);
      axw(REG_CTRL, 32'h0, RESP_OKAY);
      repeat (3) host_u.step(1'b0, 1'b0, o, oe);
      chk("test_logic_reset", test_logic_reset, 0);
      $display("test soft reset done");
      end_sim();
   end
endmodule
